// file: cfu_control_flow_unit.sv
// cfu_control_flow_unit.sv: system control instruction executer
// assumes a decoder issues opValid for one cycle while ready is high;
// the stack lives in a local memory addressed by the byte stack pointer.
// Summary of operation
// - call pushes next address, jumps, sp+=2
// - goto loads full target, stack untouched
// - return-immediate writes working register then returns
// - return drops sp by two, reloads pc
// - return from interrupt sets global enable
// - watchdog kick clears watchdog count
// - computed jump adds working register to pc
// - interrupt-on sets global interrupt enable
// - interrupt-off clears global interrupt enable
// - full halt stops all clocks, oscillators too
// - cpu halt gates system clock only
// - flow changes take two instruction cycles
`timescale 1ns/1ns
`default_nettype none
`include "cfu_regs.svh"
module cfu_control_flow_unit
  import cfu_pkg::*;
#(
  parameter int PC_W = `CFU_PC_W,
  parameter int SP_W = `CFU_SP_W,
  parameter int DW = `CFU_DATA_W
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic opValid,
  input wire cfu_op_t opCode,
  input wire logic [PC_W-1:0] target,
  input wire logic [DW-1:0] immData,
  input wire logic wakeUp,
  input wire logic [3:0] flagsIn,
  output logic ready,
  output logic [PC_W-1:0] pc,
  output logic [SP_W-1:0] sp,
  output logic [DW-1:0] workingRegister,
  output logic globalIntEnable,
  output logic watchdogClear,
  output logic sysClockGate,
  output logic oscStop,
  output logic [3:0] flagsOut
);
  logic [PC_W-1:0] pc_reg;
  logic [SP_W-1:0] sp_reg;
  logic [DW-1:0] work_reg;
  logic gie_reg;
  logic wdClr_reg;
  logic clkGate_reg;
  logic oscStop_reg;
  cfu_state_t state_reg;
  cfu_op_t pendOp_reg;
  logic [PC_W-1:0] stkRd;
  logic stkWr;
  logic [SP_W-1:0] stkAddrByte;
  logic take;
  logic [SP_W-1:0] spDown;

  // stack words are two bytes wide, so the word index drops bit zero
  function automatic logic [`CFU_STK_AW-1:0] wordIdx(input logic [SP_W-1:0] a);
    wordIdx = a[`CFU_STK_AW:1];
  endfunction : wordIdx

  function automatic logic isReturn(input cfu_op_t op);
    isReturn = (op == CFU_OP_RET) || (op == CFU_OP_RETI)
      || (op == CFU_OP_RETI_IMM);
  endfunction : isReturn

  assign take = opValid && ready;
  assign ready = (state_reg == CFU_ST_IDLE);
  assign spDown = SP_W'(sp_reg - `CFU_SP_STEP);
  // returns read one word below sp so the data is ready in the second cycle
  assign stkAddrByte = (take && isReturn(opCode)) ? spDown : sp_reg;
  assign stkWr = take && (opCode == CFU_OP_CALL);

  cfu_stack_mem #(
    .DEPTH(`CFU_STK_DEPTH),
    .AW(`CFU_STK_AW),
    .DW(PC_W)
  ) u_stack (
    .clock(clock),
    .wrEn(stkWr),
    .addr(wordIdx(stkAddrByte)),
    .wrData(PC_W'(pc_reg + `CFU_PC_STEP)),
    .rdData(stkRd)
  );

  // sequencing: flow changes hold off the next op for a second cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= CFU_ST_IDLE;
      pendOp_reg <= CFU_OP_NOP;
    end else begin
      case (state_reg)
        CFU_ST_IDLE: begin
          if (take) begin
            pendOp_reg <= opCode;
            case (opCode)
              CFU_OP_CALL, CFU_OP_GOTO, CFU_OP_RET, CFU_OP_RETI,
              CFU_OP_RETI_IMM, CFU_OP_PCADD: begin
                state_reg <= CFU_ST_SECOND;
              end
              CFU_OP_STOPSYS, CFU_OP_STOPEXE: begin
                state_reg <= CFU_ST_HALT;
              end
              default: begin
                state_reg <= CFU_ST_IDLE;
              end
            endcase
          end
        end
        CFU_ST_SECOND: begin
          state_reg <= CFU_ST_IDLE;
        end
        CFU_ST_HALT: begin
          if (wakeUp) begin
            state_reg <= CFU_ST_IDLE;
          end
        end
        default: begin
          state_reg <= CFU_ST_IDLE;
        end
      endcase
    end
  end

  // program counter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pc_reg <= `CFU_PC_RESET;
    end else if (take) begin
      case (opCode)
        CFU_OP_CALL, CFU_OP_GOTO: begin
          pc_reg <= target;
        end
        CFU_OP_PCADD: begin
          pc_reg <= PC_W'(pc_reg + PC_W'(work_reg));
        end
        CFU_OP_RET, CFU_OP_RETI, CFU_OP_RETI_IMM: begin
          pc_reg <= pc_reg;
        end
        CFU_OP_STOPSYS, CFU_OP_STOPEXE: begin
          pc_reg <= pc_reg;
        end
        default: begin
          pc_reg <= PC_W'(pc_reg + `CFU_PC_STEP);
        end
      endcase
    end else if (state_reg == CFU_ST_SECOND && isReturn(pendOp_reg)) begin
      pc_reg <= stkRd;
    end else if (state_reg == CFU_ST_HALT && wakeUp) begin
      pc_reg <= PC_W'(pc_reg + `CFU_PC_STEP);
    end
  end

  // stack pointer
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sp_reg <= `CFU_SP_RESET;
    end else if (take && opCode == CFU_OP_CALL) begin
      sp_reg <= SP_W'(sp_reg + `CFU_SP_STEP);
    end else if (take && isReturn(opCode)) begin
      sp_reg <= spDown;
    end
  end

  // working register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      work_reg <= `CFU_WORK_RESET;
    end else if (take && opCode == CFU_OP_RETI_IMM) begin
      work_reg <= immData;
    end
  end

  // global interrupt enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gie_reg <= 1'b0;
    end else if (take && opCode == CFU_OP_GIE_ON) begin
      gie_reg <= 1'b1;
    end else if (take && opCode == CFU_OP_GIE_OFF) begin
      gie_reg <= 1'b0;
    end else if (state_reg == CFU_ST_SECOND && pendOp_reg == CFU_OP_RETI) begin
      gie_reg <= 1'b1;
    end
  end

  // watchdog kick pulse
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdClr_reg <= 1'b0;
    end else begin
      wdClr_reg <= take && (opCode == CFU_OP_WDKICK);
    end
  end

  // halt controls; the clock gate itself lives in the clock module
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      clkGate_reg <= 1'b0;
      oscStop_reg <= 1'b0;
    end else if (state_reg == CFU_ST_HALT && wakeUp) begin
      clkGate_reg <= 1'b0;
      oscStop_reg <= 1'b0;
    end else if (take && opCode == CFU_OP_STOPSYS) begin
      clkGate_reg <= 1'b1;
      oscStop_reg <= 1'b1;
    end else if (take && opCode == CFU_OP_STOPEXE) begin
      clkGate_reg <= 1'b1;
      oscStop_reg <= 1'b0;
    end
  end

  assign pc = pc_reg;
  assign sp = sp_reg;
  assign workingRegister = work_reg;
  assign globalIntEnable = gie_reg;
  assign watchdogClear = wdClr_reg;
  assign sysClockGate = clkGate_reg;
  assign oscStop = oscStop_reg;
  // flags pass straight through untouched
  assign flagsOut = flagsIn;

  // back to back kicks keep the clear high, so the pulse end is checked
  // against the absence of a kick rather than a fixed width
  a_call_push: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_CALL |=>
      sp == $past(sp) + `CFU_SP_STEP && pc == $past(target))
    else $error("call did not jump and push");
  a_goto_stack: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_GOTO |=>
      pc == $past(target) && $stable(sp))
    else $error("goto wrong target or moved stack");
  a_retimm_work: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_RETI_IMM |=>
      workingRegister == $past(immData))
    else $error("return immediate lost data");
  a_retimm_pop: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_RETI_IMM |=>
      sp == $past(sp) - `CFU_SP_STEP ##1 pc == $past(stkRd))
    else $error("return immediate did not pop");
  a_ret_pop: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_RET |=>
      sp == $past(sp) - `CFU_SP_STEP ##1 pc == $past(stkRd))
    else $error("return did not pop");
  a_reti_pop: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_RETI |=>
      sp == $past(sp) - `CFU_SP_STEP ##1 pc == $past(stkRd))
    else $error("return from interrupt did not pop");
  a_reti_gie: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_RETI |->
      ##2 globalIntEnable)
    else $error("return from interrupt left interrupts off");
  a_wd_kick: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_WDKICK |=> watchdogClear)
    else $error("watchdog clear pulse missing");
  a_wd_quiet: assert property (@(posedge clock)
    disable iff (rst) !(take && opCode == CFU_OP_WDKICK) |=>
      !watchdogClear)
    else $error("watchdog clear without a kick");
  a_pcadd_sum: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_PCADD |=>
      pc == PC_W'($past(pc) + PC_W'($past(workingRegister))))
    else $error("computed jump target wrong");
  a_gie_onoff: assert property (@(posedge clock)
    disable iff (rst) take && (opCode == CFU_OP_GIE_ON
      || opCode == CFU_OP_GIE_OFF) |=>
      globalIntEnable == ($past(opCode) == CFU_OP_GIE_ON))
    else $error("global interrupt enable wrong");
  a_halt_all: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_STOPSYS |=>
      sysClockGate && oscStop)
    else $error("full halt left clocks running");
  a_halt_cpu: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_STOPEXE |=>
      sysClockGate && !oscStop)
    else $error("cpu halt wrong");
  a_halt_hold: assert property (@(posedge clock)
    disable iff (rst) state_reg == CFU_ST_HALT && !wakeUp |=>
      !ready && sysClockGate)
    else $error("halt released without a wake-up");
  a_wake_resume: assert property (@(posedge clock)
    disable iff (rst) state_reg == CFU_ST_HALT && wakeUp |=>
      ready && !sysClockGate && !oscStop)
    else $error("wake-up did not restart clocks");
  a_two_cycle: assert property (@(posedge clock)
    disable iff (rst) take && (isReturn(opCode) || opCode == CFU_OP_CALL
      || opCode == CFU_OP_GOTO || opCode == CFU_OP_PCADD) |=>
      !ready ##1 ready)
    else $error("flow change not two cycles");
  a_flags_pass: assert property (@(posedge clock)
    disable iff (rst) flagsOut == flagsIn)
    else $error("arithmetic flags altered");
  a_nop_quiet: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_NOP |=> ready
      && $stable(sp) && $stable(workingRegister)
      && $stable(globalIntEnable))
    else $error("nop changed state");
  a_nop_step: assert property (@(posedge clock)
    disable iff (rst) take && opCode == CFU_OP_NOP |=>
      pc == PC_W'($past(pc) + `CFU_PC_STEP))
    else $error("nop did not step the program counter");
endmodule : cfu_control_flow_unit
`default_nettype wire

// file: cfu_pkg.sv
// cfu_pkg.sv: operation and state types for the control flow unit
// assumes nothing beyond the register header
package cfu_pkg;
  typedef enum logic [3:0] {
    CFU_OP_NOP, CFU_OP_CALL, CFU_OP_GOTO, CFU_OP_RETI_IMM, CFU_OP_RET,
    CFU_OP_RETI, CFU_OP_WDKICK, CFU_OP_PCADD, CFU_OP_GIE_ON, CFU_OP_GIE_OFF,
    CFU_OP_STOPSYS, CFU_OP_STOPEXE
  } cfu_op_t;
  typedef enum logic [1:0] {CFU_ST_IDLE, CFU_ST_SECOND, CFU_ST_HALT} cfu_state_t;
endpackage : cfu_pkg

// file: cfu_regs.svh
// cfu_regs.svh: encodings and widths for the control flow instruction unit
// assumes the core's decoder presents one operation code per instruction
`ifndef CFU_REGS_SVH
`define CFU_REGS_SVH
`define CFU_PC_W 12
`define CFU_SP_W 8
`define CFU_DATA_W 8
`define CFU_SP_STEP 8'h02
`define CFU_PC_STEP 12'h001
`define CFU_PC_RESET 12'h000
`define CFU_SP_RESET 8'h00
`define CFU_WORK_RESET 8'h00
`define CFU_STK_DEPTH 128
`define CFU_STK_AW 7
`endif

// file: cfu_stack_mem.sv
// cfu_stack_mem.sv: word-wide return stack storage, registered read data
// assumes one write or one read per cycle from the control unit
`timescale 1ns/1ns
`default_nettype none
`include "cfu_regs.svh"
module cfu_stack_mem #(
  parameter int DEPTH = `CFU_STK_DEPTH,
  parameter int AW = `CFU_STK_AW,
  parameter int DW = `CFU_PC_W
) (
  input wire logic clock,
  input wire logic wrEn,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wrData,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [DEPTH];
  always_ff @(posedge clock) begin
    if (wrEn) begin
      mem[addr] <= wrData;
    end
    rdData <= mem[addr];
  end
endmodule : cfu_stack_mem
`default_nettype wire

// file: tb_top.sv
// tb_top.sv: self-checking bench for the control flow unit
// assumes one clock; bench drives every unit input 1 ns after a rising edge
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import cfu_pkg::*;
;
  typedef struct {
    logic [11:0] pc;
    logic [7:0] sp;
    logic [7:0] work;
    logic [4:0] bits;
    int cyc;
  } cfu_note_t;
  logic clock, rst, opValid, wakeUp;
  cfu_op_t opCode;
  logic [11:0] target;
  logic [7:0] immData;
  logic [3:0] flagsIn;
  logic ready, globalIntEnable, watchdogClear, sysClockGate, oscStop;
  logic [11:0] pc;
  logic [7:0] sp, workingRegister;
  logic [3:0] flagsOut;
  logic [11:0] mPc;
  logic [7:0] mSp, mWork;
  logic mGie;
  logic [11:0] mStk [128];
  cfu_note_t notes [$];
  int errors, samples_checked, lowCnt;
  event sampleNow;

  cfu_control_flow_unit cfu_control_flow_unit_inst (.clock(clock),
    .rst(rst), .opValid(opValid), .opCode(opCode), .target(target),
    .immData(immData), .wakeUp(wakeUp), .flagsIn(flagsIn), .ready(ready),
    .pc(pc), .sp(sp), .workingRegister(workingRegister),
    .globalIntEnable(globalIntEnable), .watchdogClear(watchdogClear),
    .sysClockGate(sysClockGate), .oscStop(oscStop), .flagsOut(flagsOut));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic note(logic wdc, logic gate, logic osc, logic rdy, int cyc);
    cfu_note_t n;
    n.pc = mPc;
    n.sp = mSp;
    n.work = mWork;
    n.bits = {mGie, wdc, gate, osc, rdy};
    n.cyc = cyc;
    notes.push_back(n);
    ->sampleNow;
  endtask : note

  // results are compared against the oldest note as soon as one is posted
  initial begin : monitor
    cfu_note_t n;
    forever begin
      @(sampleNow);
      n = notes.pop_front();
      check("pc", pc, n.pc);
      check("sp", sp, n.sp);
      check("work", workingRegister, n.work);
      check("ctl", {globalIntEnable, watchdogClear, sysClockGate, oscStop,
        ready}, n.bits);
      check("cycles", 16'(lowCnt), 16'(n.cyc));
      check("flags", flagsOut, flagsIn);
    end
  end

  task automatic doReset();
    rst = 1'b1;
    opValid = 1'b0;
    wakeUp = 1'b0;
    lowCnt = 0;
    mPc = 12'h000;
    mSp = 8'h00;
    mWork = 8'h00;
    mGie = 1'b0;
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    note(1'b0, 1'b0, 1'b0, 1'b1, 0);
  endtask : doReset

  // opValid is left high on return; the caller issues again or idles
  task automatic issue(cfu_op_t op, logic [11:0] tgt, logic [7:0] imm);
    logic flow;
    opValid = 1'b1;
    opCode = op;
    target = tgt;
    immData = imm;
    flagsIn = 4'($urandom);
    flow = op inside {CFU_OP_CALL, CFU_OP_GOTO, CFU_OP_RET, CFU_OP_RETI,
      CFU_OP_RETI_IMM, CFU_OP_PCADD};
    @(posedge clock);
    #1 lowCnt = 0;
    // a wrong take of the held request would land pc elsewhere
    if (ready !== 1'b1) target = ~tgt;
    case (op)
      CFU_OP_CALL: begin
        mStk[mSp[7:1]] = mPc + 12'h001;
        mPc = tgt;
        mSp = mSp + 8'h02;
      end
      CFU_OP_GOTO: mPc = tgt;
      CFU_OP_PCADD: mPc = mPc + 12'(mWork);
      CFU_OP_RET, CFU_OP_RETI, CFU_OP_RETI_IMM: begin
        if (op == CFU_OP_RETI_IMM) mWork = imm;
        if (op == CFU_OP_RETI) mGie = 1'b1;
        mSp = mSp - 8'h02;
        mPc = mStk[mSp[7:1]];
      end
      default: mPc = mPc + 12'h001;
    endcase
    if (op == CFU_OP_GIE_ON) mGie = 1'b1;
    if (op == CFU_OP_GIE_OFF) mGie = 1'b0;
    while (ready !== 1'b1 && lowCnt < 8) begin
      @(posedge clock);
      #1 lowCnt++;
    end
    note(op == CFU_OP_WDKICK, 1'b0, 1'b0, 1'b1, flow ? 1 : 0);
  endtask : issue

  task automatic halt(cfu_op_t op);
    opValid = 1'b1;
    opCode = op;
    @(posedge clock);
    #1 opCode = CFU_OP_GOTO;
    target = ~mPc;
    lowCnt = 0;
    note(1'b0, 1'b1, op == CFU_OP_STOPSYS, 1'b0, 0);
    repeat (3) @(posedge clock);
    #1 wakeUp = 1'b1;
    @(posedge clock);
    #1 wakeUp = 1'b0;
    mPc = mPc + 12'h001;
    note(1'b0, 1'b0, 1'b0, 1'b1, 0);
  endtask : halt

  task automatic idle(int n);
    opValid = 1'b0;
    repeat (n) @(posedge clock);
    #1;
  endtask : idle

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial begin
    #100000;
    errors++;
    conclude();
  end

  initial begin
    opCode = CFU_OP_NOP;
    target = 12'h000;
    immData = 8'h00;
    flagsIn = 4'h0;
    void'($urandom(20));
    doReset();
    issue(CFU_OP_NOP, 12'h000, 8'h00);
    issue(CFU_OP_GIE_ON, 12'h000, 8'h00);
    issue(CFU_OP_NOP, 12'h000, 8'h00);
    issue(CFU_OP_GIE_OFF, 12'h000, 8'h00);
    issue(CFU_OP_WDKICK, 12'h000, 8'h00);
    issue(CFU_OP_WDKICK, 12'h000, 8'h00);
    $display("test simple ops done");
    issue(CFU_OP_GOTO, 12'hFFF, 8'h00);
    repeat (3) issue(CFU_OP_GOTO, 12'($urandom), 8'h00);
    $display("test jumps done");
    repeat (3) issue(CFU_OP_CALL, 12'($urandom), 8'h00);
    issue(CFU_OP_RETI_IMM, 12'h000, 8'($urandom));
    issue(CFU_OP_PCADD, 12'h000, 8'h00);
    issue(CFU_OP_RET, 12'h000, 8'h00);
    issue(CFU_OP_RETI, 12'h000, 8'h00);
    issue(CFU_OP_PCADD, 12'h000, 8'h00);
    $display("test calls and returns done");
    halt(CFU_OP_STOPEXE);
    halt(CFU_OP_STOPSYS);
    issue(CFU_OP_NOP, 12'h000, 8'h00);
    $display("test halts done");
    issue(CFU_OP_CALL, 12'h5A5, 8'h00);
    idle(1);
    doReset();
    issue(CFU_OP_CALL, 12'h0F0, 8'h00);
    issue(CFU_OP_RET, 12'h000, 8'h00);
    idle(2);
    $display("test reset in mid run done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
